// *** design/switch_cfg_pkg.sv ***
// Package for the switch system configuration register bank.
// Assumes a single system clock; shared by the register bank and its users.
package switch_cfg_pkg;

  localparam int REG_ADDR_W = 5;
  localparam int CFG_W = 16;
  localparam int PORT_COUNT = 24;
  localparam int RD_W = 24;

  // Register numbers on the management port.
  localparam logic [REG_ADDR_W-1:0] ACTIVITY_ADDR = 5'h0F;
  localparam logic [REG_ADDR_W-1:0] SYS_CFG_ADDR = 5'h10;
  localparam logic [REG_ADDR_W-1:0] INT_MASK_ADDR = 5'h11;

  // Field positions in system_configuration.
  localparam int CFG_SELF_TEST_OFF = 0;
  localparam int CFG_SPAN_TREE_EN = 1;
  localparam int CFG_SYS_READY = 5;
  localparam int CFG_PHY_MGMT_DONE = 6;
  localparam int CFG_WDOG_OFF = 7;
  localparam int CFG_LEAKY_VLAN = 8;
  localparam int CFG_RX_FALL_EDGE = 9;
  localparam int CFG_LATE_BP = 10;
  localparam int CFG_BCAST_CPU = 11;
  localparam int CFG_SOFT_RESET = 12;
  localparam int CFG_LIFE_HALT = 13;

  // Writable bits of system_configuration; reserved bits 2..4, 14, 15 stay zero.
  localparam logic [CFG_W-1:0] CFG_WR_MASK = 16'h3FE3;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

  // Interrupt source positions in interrupt_source_mask.
  localparam int INT_SRC_W = 3;
  localparam int INT_INIT_DONE = 0;
  localparam int INT_SYS_ERROR = 1;
  localparam int INT_PARTITION = 2;
  localparam logic [CFG_W-1:0] MASK_RESET = 16'hFFFF;

  // Half period of the watchdog life pulse, in system clocks.
  localparam int LIFE_HALF_CYCLES = 1000;

  typedef struct packed {
    logic built_in_self_test_run;
    logic span_tree_en;
    logic system_start;
    logic mac_run;
    logic watchdog_en;
    logic leaky_vlan;
    logic rx_fall_edge;
    logic late_back_pressure;
    logic bcast_to_cpu;
  } core_ctrl_t;

endpackage : switch_cfg_pkg

// *** design/switch_system_config_regs.sv ***
// System configuration, interrupt mask and port activity registers.
// Assumes a synchronous management port with one-cycle read and write strobes and
// a single system clock; all inputs are synchronous to sys_clk_i.
//
// Notes on behaviour
// - Config bit 0 clear runs self-test.
// - Config bit 1 set enables spanning tree.
// - With CPU present, wait for bit 5.
// - With CPU present, MACs idle until bit 6.
// - Config bit 7 clear runs the watchdog.
// - Config bit 8 picks leaky over secure VLAN.
// - Config bit 9 picks falling receive clock edge.
// - Config bit 10 delays back-pressure past DA bit.
// - Writing one to bit 12 resets state machines.
// - Writing one to bit 13 stops life pulse.
// - Interrupt pin driven only by unmasked sources.
// - Mask bits 0..2 map three sources, reset one.
// - Activity register holds one bit per port.
// - All configuration bits reset to zero.
`timescale 1ns/1ps

module switch_system_config_regs #(
  parameter int LIFE_HALF = switch_cfg_pkg::LIFE_HALF_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [switch_cfg_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [switch_cfg_pkg::CFG_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [switch_cfg_pkg::RD_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic cpu_absent_i,
  input wire logic [switch_cfg_pkg::INT_SRC_W-1:0] int_event_i,
  input wire logic [switch_cfg_pkg::PORT_COUNT-1:0] port_activity_i,
  output switch_cfg_pkg::core_ctrl_t core_ctrl_o,
  output logic soft_reset_o,
  output logic life_pulse_o,
  output logic int_req_o
);
  import switch_cfg_pkg::*;

  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] mask_r;
  logic [PORT_COUNT-1:0] activity_r;
  localparam int LIFE_CNT_W = $clog2(LIFE_HALF + 1);
  logic [LIFE_CNT_W-1:0] life_cnt_r;
  core_ctrl_t ctrl_nxt;
  logic cfg_wr;
  logic mask_wr;

  function automatic logic hit(input logic [REG_ADDR_W-1:0] a,
                               input logic [REG_ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  assign cfg_wr = reg_wr_i && hit(reg_addr_i, SYS_CFG_ADDR);
  assign mask_wr = reg_wr_i && hit(reg_addr_i, INT_MASK_ADDR);

  // Reserved bits are never stored, so they read back as zero whatever is written.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_r <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg_r <= reg_wdata_i & CFG_WR_MASK;
      // The reset request is a strobe; the bit does not stay set.
      cfg_r[CFG_SOFT_RESET] <= 1'b0;
      // Once halted, the life pulse stays halted until the external reset arrives.
      cfg_r[CFG_LIFE_HALT] <= cfg_r[CFG_LIFE_HALT] | reg_wdata_i[CFG_LIFE_HALT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mask_r <= MASK_RESET;
    end else if (mask_wr) begin
      mask_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= cfg_wr && reg_wdata_i[CFG_SOFT_RESET];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      activity_r <= '0;
    end else begin
      activity_r <= port_activity_i;
    end
  end

  // Shared by the running decode and the reset value; the reset value decodes CFG_RESET with the CPU taken as present.
  function automatic core_ctrl_t decode_ctrl(input logic [CFG_W-1:0] cfg,
                                             input logic cpu_absent);
    core_ctrl_t c;
    c.built_in_self_test_run = !cfg[CFG_SELF_TEST_OFF];
    c.span_tree_en = cfg[CFG_SPAN_TREE_EN];
    c.system_start = cpu_absent || cfg[CFG_SYS_READY];
    c.mac_run = cpu_absent || cfg[CFG_PHY_MGMT_DONE];
    c.watchdog_en = !cfg[CFG_WDOG_OFF];
    c.leaky_vlan = cfg[CFG_LEAKY_VLAN];
    c.rx_fall_edge = cfg[CFG_RX_FALL_EDGE];
    c.late_back_pressure = cfg[CFG_LATE_BP];
    c.bcast_to_cpu = cfg[CFG_BCAST_CPU];
    decode_ctrl = c;
  endfunction : decode_ctrl

  always_comb begin
    ctrl_nxt = decode_ctrl(cfg_r, cpu_absent_i);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      // Self-test and watchdog are already enabled while reset is held.
      core_ctrl_o <= decode_ctrl(CFG_RESET, 1'b0);
    end else begin
      core_ctrl_o <= ctrl_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      int_req_o <= 1'b0;
    end else begin
      int_req_o <= |(int_event_i & mask_r[INT_SRC_W-1:0]);
    end
  end

  // The life pulse toggles while not halted; the external watchdog
  // fires when toggling stops.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      life_cnt_r <= '0;
      life_pulse_o <= 1'b0;
    end else if (!cfg_r[CFG_LIFE_HALT]) begin
      if (life_cnt_r == LIFE_CNT_W'(LIFE_HALF - 1)) begin
        life_cnt_r <= '0;
        life_pulse_o <= !life_pulse_o;
      end else begin
        life_cnt_r <= life_cnt_r + 1'b1;
      end
    end
  end

  // Read data is registered; unmapped register numbers read as zero.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (!reg_rd_i) begin
        reg_rdata_o <= '0;
      end else if (hit(reg_addr_i, SYS_CFG_ADDR)) begin
        reg_rdata_o <= {8'h00, cfg_r};
      end else if (hit(reg_addr_i, INT_MASK_ADDR)) begin
        reg_rdata_o <= {8'h00, mask_r};
      end else if (hit(reg_addr_i, ACTIVITY_ADDR)) begin
        reg_rdata_o <= activity_r;
      end else begin
        reg_rdata_o <= '0;
      end
    end
  end

  // Helper: cycles since the life pulse last changed.
  logic [$clog2(LIFE_HALF+1):0] stall_cnt_r;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || life_pulse_o != $past(life_pulse_o)) begin
      stall_cnt_r <= '0;
    end else if (stall_cnt_r != '1) begin
      stall_cnt_r <= stall_cnt_r + 1'b1;
    end
  end

  self_test_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    core_ctrl_o.built_in_self_test_run == !$past(cfg_r[CFG_SELF_TEST_OFF]))
    else $error("self-test enable does not follow bit 0");

  span_tree_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cfg_wr ##1 1'b1 |=> core_ctrl_o.span_tree_en == $past(reg_wdata_i[CFG_SPAN_TREE_EN], 2))
    else $error("spanning tree enable does not follow bit 1");

  start_wait_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!$past(cpu_absent_i) && !$past(cfg_r[CFG_SYS_READY])) |-> !core_ctrl_o.system_start)
    else $error("system started before the CPU released it");

  mac_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!$past(cpu_absent_i) && !$past(cfg_r[CFG_PHY_MGMT_DONE])) |-> !core_ctrl_o.mac_run)
    else $error("MACs ran before PHY management completed");

  watchdog_en_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    core_ctrl_o.watchdog_en != $past(cfg_r[CFG_WDOG_OFF]))
    else $error("watchdog enable does not follow bit 7");

  vlan_edge_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    {core_ctrl_o.rx_fall_edge, core_ctrl_o.leaky_vlan} ==
    $past(cfg_r[CFG_RX_FALL_EDGE:CFG_LEAKY_VLAN]) )
    else $error("VLAN rule or receive edge select is wrong");

  late_bp_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    {core_ctrl_o.bcast_to_cpu, core_ctrl_o.late_back_pressure} ==
    $past(cfg_r[CFG_BCAST_CPU:CFG_LATE_BP]))
    else $error("back-pressure or broadcast select is wrong");

  soft_reset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cfg_wr && reg_wdata_i[CFG_SOFT_RESET]) |=> soft_reset_o)
    else $error("software reset strobe missing");

  life_halt_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cfg_r[CFG_LIFE_HALT] |=> $stable(life_pulse_o))
    else $error("life pulse toggled while halted");

  life_run_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !cfg_r[CFG_LIFE_HALT] |-> stall_cnt_r <= LIFE_HALF)
    else $error("life pulse stalled while running");

  int_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    int_req_o == |($past(int_event_i) & $past(mask_r[INT_SRC_W-1:0])))
    else $error("interrupt request not gated by the mask");

  mask_reset_a: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> mask_r == MASK_RESET && cfg_r == CFG_RESET)
    else $error("mask or configuration reset value wrong");

  activity_rd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && hit(reg_addr_i, ACTIVITY_ADDR)) ##1 reg_rvalid_o |->
    reg_rdata_o == $past(port_activity_i, 2))
    else $error("activity read does not show port activity");

  reserved_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cfg_r & ~CFG_WR_MASK) == '0)
    else $error("reserved configuration bit set");

  // Read answers come one cycle after the strobe and the bus idles at zero.
  rvalid_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe not answered in the next cycle");

  idle_rdata_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> (reg_rdata_o == '0) && !reg_rvalid_o)
    else $error("read bus not idle without a read");

  cfg_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && hit(reg_addr_i, SYS_CFG_ADDR)) |=> reg_rdata_o == {8'h00, $past(cfg_r)})
    else $error("configuration read returns wrong data");

  mask_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && hit(reg_addr_i, INT_MASK_ADDR)) |=> reg_rdata_o == {8'h00, $past(mask_r)})
    else $error("mask read returns wrong data");

  cfg_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cfg_wr |=> cfg_r[CFG_BCAST_CPU:0] ==
    ($past(reg_wdata_i[CFG_BCAST_CPU:0]) & CFG_WR_MASK[CFG_BCAST_CPU:0]))
    else $error("configuration write did not land");

  mask_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    mask_wr |=> mask_r == $past(reg_wdata_i))
    else $error("mask write did not land");

  soft_once_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    soft_reset_o |-> $past(cfg_wr && reg_wdata_i[CFG_SOFT_RESET]))
    else $error("software reset strobe without a write");

  halt_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cfg_wr && reg_wdata_i[CFG_LIFE_HALT]) |=> cfg_r[CFG_LIFE_HALT])
    else $error("life halt request not stored");

  halt_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cfg_r[CFG_LIFE_HALT] |=> cfg_r[CFG_LIFE_HALT])
    else $error("life halt cleared without reset");

  start_run_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_absent_i || cfg_r[CFG_SYS_READY]) |=> core_ctrl_o.system_start)
    else $error("system start withheld after release");

  mac_run_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_absent_i || cfg_r[CFG_PHY_MGMT_DONE]) |=> core_ctrl_o.mac_run)
    else $error("MACs held idle after PHY management completed");

  init_irq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (int_event_i[INT_INIT_DONE] && mask_r[INT_INIT_DONE]) |=> int_req_o)
    else $error("initialization done did not raise the interrupt");

  error_irq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (int_event_i[INT_SYS_ERROR] && mask_r[INT_SYS_ERROR]) |=> int_req_o)
    else $error("system error did not raise the interrupt");

  partition_irq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (int_event_i[INT_PARTITION] && mask_r[INT_PARTITION]) |=> int_req_o)
    else $error("port partition did not raise the interrupt");

  soft_reset_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    soft_reset_o);
  start_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !cpu_absent_i && $rose(core_ctrl_o.mac_run));
  halt_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(cfg_r[CFG_LIFE_HALT]));
  int_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(int_req_o));

endmodule : switch_system_config_regs

// *** verif/cpu_model.sv ***
// Control CPU model that drives the management register port.
// Assumes the bank answers a read in the cycle after the strobe edge.
`timescale 1ns/1ps
module cpu_model (
  input wire logic sys_clk_i,
  input wire logic [23:0] rdata_i,
  input wire logic rvalid_i,
  output logic [4:0] addr_o,
  output logic wr_o,
  output logic [15:0] wdata_o,
  output logic rd_o
);
  import switch_cfg_pkg::*;
  initial begin
    addr_o = 5'h1F;
    wr_o = 1'b0;
    wdata_o = 16'hA5A5;
    rd_o = 1'b0;
  end
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= (a == SYS_CFG_ADDR) ? (d & CFG_WR_MASK) : d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg
  // A missing answer hands back unknowns, so any compare against it fails.
  task automatic rd_reg(input logic [4:0] a, output logic [23:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rvalid_i ? rdata_i : 24'hxxxxxx;
  endtask : rd_reg
endmodule : cpu_model

// *** verif/tb_switch_system_config_regs.sv ***
// Self-checking bench for the configuration register bank.
// Assumes cpu_model as bus master and a 40 MHz system clock.
`timescale 1ns/1ps
module tb_switch_system_config_regs;
  import switch_cfg_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [23:0] rdata;
  logic rvalid;
  logic cpu_absent = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [23:0] act = 24'h000000;
  core_ctrl_t ctrl;
  logic soft_rst;
  logic life;
  logic irq;
  logic [23:0] d;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  cpu_model cpu (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
  switch_system_config_regs #(.LIFE_HALF(4)) DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .cpu_absent_i(cpu_absent),
    .int_event_i(ev), .port_activity_i(act), .core_ctrl_o(ctrl),
    .soft_reset_o(soft_rst), .life_pulse_o(life), .int_req_o(irq));
  task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  function automatic core_ctrl_t exp_ctrl(input logic [15:0] c, input logic a);
    return '{~c[0], c[1], c[5] | a, c[6] | a, ~c[7], c[8], c[9], c[10], c[11]};
  endfunction : exp_ctrl
  task automatic t_reset();
    cpu.rd_reg(SYS_CFG_ADDR, d);
    check("cfg reset", d, 24'h000000);
    cpu.rd_reg(INT_MASK_ADDR, d);
    check("mask reset", d, 24'h00FFFF);
    check("ctrl reset", 24'(ctrl), 24'(exp_ctrl(16'h0000, 1'b0)));
  endtask : t_reset
  task automatic t_fields();
    int bits[9] = '{0, 1, 5, 6, 7, 8, 9, 10, 11};
    logic [15:0] c;
    foreach (bits[i]) begin
      c = 16'h0001 << bits[i];
      cpu.wr_reg(SYS_CFG_ADDR, c);
      @(posedge sys_clk_i);
      #1;
      check("ctrl", 24'(ctrl), 24'(exp_ctrl(c, 1'b0)));
      cpu.rd_reg(SYS_CFG_ADDR, d);
      check("cfg read", d, 24'(c));
    end
    cpu.wr_reg(SYS_CFG_ADDR, 16'h0000);
    cpu_absent <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    check("no cpu", 24'(ctrl), 24'(exp_ctrl(16'h0000, 1'b1)));
    @(posedge sys_clk_i);
    cpu_absent <= 1'b0;
  endtask : t_fields
  task automatic t_soft();
    cpu.wr_reg(SYS_CFG_ADDR, 16'h1000);
    #1;
    check("soft on", 24'(soft_rst), 24'h000001);
    @(posedge sys_clk_i);
    #1;
    check("soft off", 24'(soft_rst), 24'h000000);
    cpu.rd_reg(SYS_CFG_ADDR, d);
    check("soft read", d, 24'h000000);
  endtask : t_soft
  task automatic t_irq();
    logic [2:0] m;
    for (int k = 0; k < 8; k++) begin
      m = 3'(k);
      cpu.wr_reg(INT_MASK_ADDR, {13'h0000, m});
      for (int i = 0; i < 3; i++) begin
        @(posedge sys_clk_i);
        ev <= 3'h1 << i;
        @(posedge sys_clk_i);
        #1;
        check("irq", 24'(irq), 24'(m[i]));
      end
    end
    @(posedge sys_clk_i);
    ev <= 3'h0;
  endtask : t_irq
  task automatic t_act();
    logic [23:0] pats[2] = '{24'h800001, 24'h5AA5C3};
    foreach (pats[i]) begin
      @(posedge sys_clk_i);
      act <= pats[i];
      cpu.rd_reg(ACTIVITY_ADDR, d);
      check("activity", d, pats[i]);
    end
    cpu.wr_reg(ACTIVITY_ADDR, 16'hFFFF);
    cpu.rd_reg(5'h03, d);
    check("unmapped", d, 24'h000000);
    cpu.rd_reg(ACTIVITY_ADDR, d);
    check("act ro", d, pats[1]);
  endtask : t_act
  // Counts life pulse edges over 16 cycles; four are due at a half period of 4.
  task automatic toggles(output int n);
    logic p;
    n = 0;
    @(posedge sys_clk_i);
    #1;
    p = life;
    repeat (16) begin
      @(posedge sys_clk_i);
      #1;
      if (life !== p) n++;
      p = life;
    end
  endtask : toggles
  task automatic t_life();
    int n;
    toggles(n);
    check("life run", 24'(n), 24'h000004);
    cpu.wr_reg(SYS_CFG_ADDR, 16'h2000);
    cpu.wr_reg(SYS_CFG_ADDR, 16'h0000);
    toggles(n);
    check("life halt", 24'(n), 24'h000000);
    cpu.rd_reg(SYS_CFG_ADDR, d);
    check("halt sticky", d, 24'h002000);
  endtask : t_life
  // A reset in mid-run must clear the sticky halt and every setting.
  task automatic t_rerst();
    int n;
    cpu.wr_reg(SYS_CFG_ADDR, 16'h0FE3);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    check("ctrl rerst", 24'(ctrl), 24'(exp_ctrl(16'h0000, 1'b0)));
    cpu.rd_reg(SYS_CFG_ADDR, d);
    check("cfg rerst", d, 24'h000000);
    cpu.rd_reg(INT_MASK_ADDR, d);
    check("mask rerst", d, 24'h00FFFF);
    toggles(n);
    check("life rerst", 24'(n), 24'h000004);
  endtask : t_rerst
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_fields();
    t_soft();
    t_irq();
    t_act();
    t_life();
    t_rerst();
    finish_test();
  end
endmodule : tb_switch_system_config_regs
